/* src/qdcc_pkg.sv */
package qdcc_pkg;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int         FRAME_W      = 24;
    localparam int         RW_BIT       = 23;
    localparam int         ADDR_HI      = 19;
    localparam int         ADDR_LO      = 16;
    localparam int         DATA_HI      = 15;
    localparam int         NUM_CH       = 4;
    localparam int         DAC_W        = 12;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CMD     = 4'h0;
    localparam logic [3:0] ADDR_DAC0    = 4'h4;

    // ------------------------------------------------------------
    // Command register field positions
    // ------------------------------------------------------------
    localparam int         BIT_RDSRC    = 15;
    localparam int         BIT_SWLOAD   = 14;
    localparam int         BIT_SWRST    = 13;
    localparam int         BIT_PDLOW    = 12;
    localparam int         BIT_PDHIGH   = 11;
    localparam int         BIT_RSVD     = 10;
    localparam int         BIT_GPIO1    = 9;
    localparam int         BIT_GPIO0    = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] GPIO_RST     = 2'h3;
    localparam logic [7:0] LOW_BYTE_RST = 8'h3c;
endpackage : qdcc_pkg

/* src/qdcc_sync2.sv */
// Two-flop synchroniser for the open-drain pin levels
module qdcc_sync2 (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [1:0] d,
    output logic      [1:0] q
);
    typedef struct packed {
        logic [1:0] meta_ff;
        logic [1:0] out_ff;
    } qdcc_sync_st_t;

    qdcc_sync_st_t st_ff;
    qdcc_sync_st_t nxt_st;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.meta_ff = d;
        nxt_st.out_ff  = st_ff.meta_ff;
    end

    // Registers, pins idle high after reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{meta_ff: 2'h3, out_ff: 2'h3};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.out_ff;
endmodule : qdcc_sync2

/* src/qdcc_ctrl.sv */
module qdcc_ctrl (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        frame_valid,
    input  wire logic [23:0] frame_data,
    input  wire logic        latch_load_pin_n,
    input  wire logic [1:0]  gpio_in,
    output logic      [1:0]  gpio_out,
    output logic      [1:0]  gpio_oe_n,
    output logic             rd_valid,
    output logic      [15:0] rd_data,
    output logic      [1:0]  powerdown,
    output logic      [47:0] latch_data,
    output logic      [3:0]  latch_update
);
    typedef struct packed {
        logic                   rdsrc_ff;
        logic                   pd_low_ff;
        logic                   pd_high_ff;
        logic [1:0]             gpio_ctl_ff;
        logic [3:0]             written_ff;
        logic [3:0][11:0]       input_ff;
        logic [3:0][11:0]       latch_ff;
        logic [3:0]             upd_ff;
        logic                   pin_d_ff;
        logic                   rd_valid_ff;
        logic [15:0]            rd_data_ff;
        logic                   soft_rst_ff;
    } qdcc_st_t;

    qdcc_st_t   st_ff;
    qdcc_st_t   nxt_st;
    logic [1:0] gpio_sync;
    logic       is_write;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic       cmd_wr;
    logic       soft_load_all;
    logic       pin_load;
    logic       load_evt;
    logic [3:0] ch_wr;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // two flop sync
    qdcc_sync2 u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       (gpio_in),
        .q       (gpio_sync)
    );

    // ------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------
    // frame field split
    assign is_write = frame_valid && !frame_data[qdcc_pkg::RW_BIT]
                      && (frame_data[22:20] == 3'h0);
    assign addr     = frame_data[qdcc_pkg::ADDR_HI:qdcc_pkg::ADDR_LO];
    assign wdata    = frame_data[qdcc_pkg::DATA_HI:0];
    assign cmd_wr   = is_write && (addr == qdcc_pkg::ADDR_CMD);
    assign soft_load_all = cmd_wr && wdata[qdcc_pkg::BIT_SWLOAD] && latch_load_pin_n;
    // Falling edge on the load pin
    assign pin_load = st_ff.pin_d_ff && !latch_load_pin_n;
    assign load_evt = soft_load_all || pin_load;

    // Per-channel data write strobes
    genvar g;
    for (g = 0; g < qdcc_pkg::NUM_CH; g++) begin : g_ch
        assign ch_wr[g] = is_write && (addr == qdcc_pkg::ADDR_DAC0 + 4'(g));
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st              = st_ff;
        nxt_st.pin_d_ff     = latch_load_pin_n;
        nxt_st.upd_ff       = 4'h0;
        nxt_st.rd_valid_ff  = 1'b0;
        if (cmd_wr) begin
            nxt_st.rdsrc_ff    = wdata[qdcc_pkg::BIT_RDSRC];
            nxt_st.pd_low_ff   = wdata[qdcc_pkg::BIT_PDLOW];
            nxt_st.pd_high_ff  = wdata[qdcc_pkg::BIT_PDHIGH];
            nxt_st.gpio_ctl_ff = wdata[qdcc_pkg::BIT_GPIO1:qdcc_pkg::BIT_GPIO0];
        end
        for (int i = 0; i < qdcc_pkg::NUM_CH; i++) begin
            if (load_evt && st_ff.written_ff[i]) begin
                nxt_st.latch_ff[i] = st_ff.input_ff[i];
                nxt_st.upd_ff[i]   = 1'b1;
            end
            if (load_evt) begin
                nxt_st.written_ff[i] = 1'b0;
            end
            if (ch_wr[i]) begin
                nxt_st.input_ff[i]   = wdata[15:4];
                nxt_st.written_ff[i] = 1'b1;
            end
        end
        if (frame_valid && frame_data[qdcc_pkg::RW_BIT]) begin
            nxt_st.rd_valid_ff = 1'b1;
            nxt_st.rd_data_ff  = 16'h0000;
            if (addr == qdcc_pkg::ADDR_CMD) begin
                // self-clear bits and reserved read zero
                nxt_st.rd_data_ff = {st_ff.rdsrc_ff, 1'b0, 1'b0, st_ff.pd_low_ff,
                                     st_ff.pd_high_ff, 1'b0, gpio_sync,
                                     qdcc_pkg::LOW_BYTE_RST};
                nxt_st.rd_data_ff[qdcc_pkg::BIT_GPIO1:qdcc_pkg::BIT_GPIO0] = gpio_sync;
            end else if (addr[3:2] == 2'h1) begin
                nxt_st.rd_data_ff = {st_ff.rdsrc_ff ? st_ff.latch_ff[addr[1:0]]
                                                    : st_ff.input_ff[addr[1:0]], 4'h0};
            end
        end
        nxt_st.soft_rst_ff = cmd_wr && wdata[qdcc_pkg::BIT_SWRST];
        // Pulse returns all state to reset values, frames dropped
        if (st_ff.soft_rst_ff) begin
            nxt_st             = '0;
            nxt_st.gpio_ctl_ff = qdcc_pkg::GPIO_RST;
            nxt_st.pin_d_ff    = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // reset values
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff             <= '0;
            st_ff.gpio_ctl_ff <= qdcc_pkg::GPIO_RST;
            st_ff.pin_d_ff    <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign gpio_out     = 2'h0;
    assign gpio_oe_n    = st_ff.gpio_ctl_ff;
    assign rd_valid     = st_ff.rd_valid_ff;
    assign rd_data      = st_ff.rd_data_ff;
    assign powerdown    = {st_ff.pd_high_ff, st_ff.pd_low_ff};
    assign latch_data   = st_ff.latch_ff;
    assign latch_update = st_ff.upd_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_soft_load_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (soft_load_all && st_ff.written_ff[0] && !st_ff.soft_rst_ff)
        |=> (st_ff.latch_ff[0] == $past(st_ff.input_ff[0]))) else $error("soft load copy");
    a_soft_load_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (soft_load_all && st_ff.written_ff[2] && !st_ff.soft_rst_ff)
        |=> latch_update[2]) else $error("no update pulse");
    a_pin_load_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pin_load && st_ff.written_ff[0] && !st_ff.soft_rst_ff)
        |=> (st_ff.latch_ff[0] == $past(st_ff.input_ff[0]))) else $error("pin load copy");
    a_load_untouched: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!st_ff.written_ff[1]) |=> $stable(st_ff.latch_ff[1]) || $past(st_ff.soft_rst_ff))
        else $error("unwritten latch changed");
    a_pin_gates_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_wr && wdata[qdcc_pkg::BIT_SWLOAD] && !latch_load_pin_n && !pin_load)
        |=> (latch_update == 4'h0)) else $error("load not gated");
    a_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (load_evt && ch_wr == 4'h0 && !st_ff.soft_rst_ff) |=> (st_ff.written_ff == 4'h0))
        else $error("written flags kept");
    a_written_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ch_wr[2] && !st_ff.soft_rst_ff) |=> st_ff.written_ff[2]) else $error("written flag not set");
    a_soft_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_ff.soft_rst_ff |=> (powerdown == 2'h0 && gpio_oe_n == 2'h3)) else $error("soft reset");
    a_pd_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_wr && !st_ff.soft_rst_ff) |=> (powerdown[0] == $past(wdata[qdcc_pkg::BIT_PDLOW])))
        else $error("pd low");
    a_pd_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_wr && !st_ff.soft_rst_ff) |=> (powerdown[1] == $past(wdata[qdcc_pkg::BIT_PDHIGH])))
        else $error("pd high");
    a_gpio_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_wr && !st_ff.soft_rst_ff)
        |=> (gpio_oe_n == $past(wdata[qdcc_pkg::BIT_GPIO1:qdcc_pkg::BIT_GPIO0]))) else $error("gpio ctl");

    // ------------------------------------------------------------
    // Read-back checks
    // ------------------------------------------------------------
    a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_valid && $past(addr) == qdcc_pkg::ADDR_CMD)
        |-> (rd_data[qdcc_pkg::BIT_RSVD] == 1'b0)) else $error("reserved set");
    a_read_self_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_valid && $past(addr) == qdcc_pkg::ADDR_CMD)
        |-> (rd_data[qdcc_pkg::BIT_SWLOAD] == 1'b0 && rd_data[qdcc_pkg::BIT_SWRST] == 1'b0))
        else $error("self-clear bit set");
    a_pin_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_valid && $past(addr) == qdcc_pkg::ADDR_CMD)
        |-> (rd_data[qdcc_pkg::BIT_GPIO1:qdcc_pkg::BIT_GPIO0] == $past(gpio_in, 3))) else $error("pin level");
    a_rdsrc_input: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (frame_valid && frame_data[qdcc_pkg::RW_BIT] && addr == qdcc_pkg::ADDR_DAC0
         && !st_ff.rdsrc_ff && !st_ff.soft_rst_ff)
        |=> (rd_data[15:4] == $past(st_ff.input_ff[0]))) else $error("input read-back");
    a_rdsrc_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (frame_valid && frame_data[qdcc_pkg::RW_BIT] && addr == qdcc_pkg::ADDR_DAC0
         && st_ff.rdsrc_ff && !st_ff.soft_rst_ff)
        |=> (rd_data[15:4] == $past(st_ff.latch_ff[0]))) else $error("latch read-back");
endmodule : qdcc_ctrl

/* dv/qdcc_host.sv */
// Host side: frame source and open-drain pin wiring
module qdcc_host (
    input  wire logic        clk_sys,
    output logic             frame_valid,
    output logic      [23:0] frame_data,
    input  wire logic [1:0]  gpio_oe_n,
    input  wire logic [1:0]  ext_low,
    output logic      [1:0]  gpio_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pull-up pins, low when driven or pulled outside
    assign gpio_in = gpio_oe_n & ~ext_low;

    // Idle bus at time zero
    initial begin
        frame_valid = 1'b0;
        frame_data  = 24'h0;
    end

    task automatic send(input logic [7:0] hdr, input logic [15:0] data);
        @(posedge clk_sys);
        #1;
        frame_valid = 1'b1;
        frame_data  = {hdr, data};
        @(posedge clk_sys);
        #1;
        frame_valid = 1'b0;
        frame_data  = ~frame_data; // Stale data never repeats
    endtask : send
endmodule : qdcc_host

/* dv/qdcc_ctrl_tb.sv */
// Self-checking bench for the command control block
module qdcc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys;
    logic        rst_n;
    logic        frame_valid;
    logic [23:0] frame_data;
    logic        latch_load_pin_n;
    logic [1:0]  gpio_in, gpio_out, gpio_oe_n, powerdown, ext_low;
    logic        rd_valid;
    logic [15:0] rd_data;
    logic [47:0] latch_data;
    logic [3:0]  latch_update, upd;
    int          error_cnt, checks_done;

    qdcc_ctrl qdcc_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n), .frame_valid(frame_valid),
        .frame_data(frame_data), .latch_load_pin_n(latch_load_pin_n), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .rd_valid(rd_valid), .rd_data(rd_data),
        .powerdown(powerdown), .latch_data(latch_data), .latch_update(latch_update));
    qdcc_host qdcc_host_i (.clk_sys(clk_sys), .frame_valid(frame_valid), .frame_data(frame_data),
        .gpio_oe_n(gpio_oe_n), .ext_low(ext_low), .gpio_in(gpio_in));

    // Clock
    always #5 clk_sys = ~clk_sys;

    // Compare and count
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Read one register and compare
    task automatic rd(input logic [7:0] hdr, input logic [15:0] exp);
        qdcc_host_i.send(hdr, 16'h0);
        check(rd_valid, 1'b1);
        check(rd_data, exp);
    endtask : rd

    // Bounded wait for a latch update pulse, current cycle first
    task automatic wait_upd;
        upd = latch_update;
        for (int i = 0; i < 5 && upd === 4'h0; i++) begin
            @(posedge clk_sys);
            #1;
            upd = latch_update;
        end
    endtask : wait_upd

    task automatic t_reset;
        rd(8'h80, 16'h033c);
        check(gpio_oe_n, 2'h3);
        check(powerdown, 2'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_soft_load;
        qdcc_host_i.send(8'h04, 16'habc0);
        qdcc_host_i.send(8'h06, 16'h1230);
        qdcc_host_i.send(8'h00, 16'h4300);
        wait_upd;
        check(upd, 4'h5);
        check(latch_data, {12'h0, 12'h123, 12'h0, 12'habc});
        rd(8'h80, 16'h033c);
        qdcc_host_i.send(8'h04, 16'h5550);
        rd(8'h84, 16'h5550);
        qdcc_host_i.send(8'h00, 16'h8300);
        rd(8'h84, 16'habc0);
        $display("test soft load done");
    endtask : t_soft_load

    task automatic t_pin_load;
        latch_load_pin_n = 1'b0;
        wait_upd;
        check(upd, 4'h1);
        check(latch_data[11:0], 12'h555);
        qdcc_host_i.send(8'h07, 16'h7770);
        qdcc_host_i.send(8'h00, 16'hc300);
        wait_upd;
        check(upd, 4'h0);
        latch_load_pin_n = 1'b1;
        wait_upd;
        check(upd, 4'h0);
        qdcc_host_i.send(8'h00, 16'hc300);
        wait_upd;
        check(upd, 4'h8);
        $display("test pin load done");
    endtask : t_pin_load

    task automatic t_power_rsvd;
        qdcc_host_i.send(8'h00, 16'h1700);
        check(powerdown, 2'h1);
        rd(8'h80, 16'h133c);
        qdcc_host_i.send(8'h00, 16'h0b00);
        check(powerdown, 2'h2);
        qdcc_host_i.send(8'h70, 16'h0300);
        check(powerdown, 2'h2);
        $display("test power done");
    endtask : t_power_rsvd

    task automatic t_gpio;
        qdcc_host_i.send(8'h00, 16'h0200);
        check(gpio_oe_n, 2'h2);
        check(gpio_out, 2'h0);
        repeat (3) @(posedge clk_sys);
        rd(8'h80, 16'h023c);
        ext_low = 2'h2;
        repeat (3) @(posedge clk_sys);
        rd(8'h80, 16'h003c);
        ext_low = 2'h0;
        $display("test gpio done");
    endtask : t_gpio

    task automatic t_soft_reset;
        qdcc_host_i.send(8'h00, 16'h3800);
        check(powerdown, 2'h3);
        check(gpio_oe_n, 2'h0);
        repeat (2) @(posedge clk_sys);
        #1;
        check(powerdown, 2'h0);
        check(gpio_oe_n, 2'h3);
        check(latch_data, 48'h0);
        rd(8'h80, 16'h033c);
        $display("test soft reset done");
    endtask : t_soft_reset

    // Counts and verdict
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // Reset, then scenarios in turn
    initial begin
        clk_sys          = 1'b0;
        rst_n            = 1'b0;
        latch_load_pin_n = 1'b1;
        ext_low          = 2'h0;
        error_cnt        = 0;
        checks_done      = 0;
        repeat (3) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_reset;
        t_soft_load;
        t_pin_load;
        t_power_rsvd;
        t_gpio;
        t_soft_reset;
        finish_test;
    end
endmodule : qdcc_ctrl_tb
